//--- hw/cam_ctrl_pkg.sv
// Constants for the camera function control register bank.
// Assumes the link controller presents quadlet requests with 48-bit destination offsets.
package cam_ctrl_pkg;

  // Bank base and decode
  localparam logic [47:0] BASE_ADDR        = 48'hFFFF_F0F0_0000;
  localparam int          OFFSET_W         = 12;
  localparam logic [11:0] OFF_INITIALIZE   = 12'h000;
  localparam logic [11:0] OFF_FRAME_RATE   = 12'h600;
  localparam logic [11:0] OFF_VIDEO_MODE   = 12'h604;
  localparam logic [11:0] OFF_VIDEO_FORMAT = 12'h608;
  localparam logic [11:0] OFF_ISO_CHAN_SPD = 12'h60C;
  localparam logic [11:0] OFF_CAM_POWER    = 12'h610;
  localparam logic [11:0] OFF_ISO_ENABLE   = 12'h614;
  localparam logic [11:0] OFF_RSVD_618     = 12'h618;
  localparam logic [11:0] OFF_SINGLE_FRAME = 12'h61C;
  localparam logic [11:0] OFF_RSVD_LAST    = 12'h624;

  // Field positions in little-endian bit index; quadlet bit 0 is bit 31
  localparam int SEL_MSB   = 31;  // 3-bit selectors, quadlet bits 0..2
  localparam int SEL_LSB   = 29;
  localparam int CHAN_MSB  = 31;  // channel, quadlet bits 0..3
  localparam int CHAN_LSB  = 28;
  localparam int SPEED_MSB = 25;  // speed, quadlet bits 6..7
  localparam int SPEED_LSB = 24;
  localparam int FLAG_BIT  = 31;  // one-bit flags, quadlet bit 0

  // Reset values
  localparam logic [2:0] RST_SELECTOR = 3'h0;
  localparam logic [3:0] RST_CHANNEL  = 4'h0;
  localparam logic [1:0] RST_SPEED    = 2'h0;
  localparam logic       RST_FLAG     = 1'b0;

  // Speed codes
  localparam logic [1:0] SPEED_S100 = 2'h0;
  localparam logic [1:0] SPEED_S200 = 2'h1;
  localparam logic [1:0] SPEED_S400 = 2'h2;

  // Frame rate code zero
  localparam logic [2:0] RATE_CODE_ZERO = 3'h0;

  // Single-frame sequencer states
  typedef enum logic [1:0] {
    SF_IDLE = 2'b00,
    SF_WAIT = 2'b01,
    SF_SEND = 2'b10
  } single_frame_state_t;

endpackage

//--- hw/camera_function_control_regs.sv
// Camera function control register bank with single-frame sequencer.
// Assumes the link controller issues at most one quadlet request per cycle on clk, and
// the video path reports frame start and end as one-cycle pulses on the same clock.
//
// Overview of operation
// - Registers decode at byte offsets from base FFFF F0F0 0000h.
// - Initialize register at offset zero has no function, reads zero.
// - Frame rate register holds three-bit selector, codes 0 to 7.
// - Video mode register holds three-bit selector, codes 0 to 7.
// - Video format register holds three-bit selector, codes 0 to 7.
// - Four-bit isochronous channel field, bits 4 and 5 reserved.
// - Two-bit speed code: 0 s100, 1 s200, 2 s400.
// - Camera power bit is the on/off state; 1 up, 0 down.
// - Camera power pin follows the power bit one clock later, through a flip-flop.
// - Transmit enable bit starts and stops continuous video transmission.
// - Writing single-frame bit 1 sends exactly one video frame.
// - Single-frame bit clears itself after that frame is fully sent.
// - Single-frame request ignored while transmit enable is 1.
`timescale 1ns/100ps

module camera_function_control_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [47:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             resp_valid,
  output logic             resp_hit,
  output logic [31:0]      resp_rdata,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  output logic [2:0]       frame_rate,
  output logic [2:0]       video_mode,
  output logic [2:0]       video_format,
  output logic [3:0]       iso_channel,
  output logic [1:0]       iso_speed,
  output logic             cam_power,
  output logic             video_tx_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [11:0] offset;
  logic        base_match;
  logic        in_bank;
  logic        wr;
  logic        rd;
  logic        hit_init;
  logic        hit_rate;
  logic        hit_mode;
  logic        hit_format;
  logic        hit_chan;
  logic        hit_power;
  logic        hit_enable;
  logic        hit_single;

  assign offset     = req_addr[11:0];
  assign base_match = (req_addr[47:12] == cam_ctrl_pkg::BASE_ADDR[47:12]);
  // Only quadlet-aligned offsets 000h and 600h..624h belong to this bank
  assign in_bank    = base_match && (offset[1:0] == 2'h0) &&
                      ((offset == cam_ctrl_pkg::OFF_INITIALIZE) ||
                       ((offset >= cam_ctrl_pkg::OFF_FRAME_RATE) &&
                        (offset <= cam_ctrl_pkg::OFF_RSVD_LAST)));
  assign wr         = req_valid && req_write && in_bank;
  assign rd         = req_valid && !req_write;
  assign hit_init   = offset == cam_ctrl_pkg::OFF_INITIALIZE;
  assign hit_rate   = offset == cam_ctrl_pkg::OFF_FRAME_RATE;
  assign hit_mode   = offset == cam_ctrl_pkg::OFF_VIDEO_MODE;
  assign hit_format = offset == cam_ctrl_pkg::OFF_VIDEO_FORMAT;
  assign hit_chan   = offset == cam_ctrl_pkg::OFF_ISO_CHAN_SPD;
  assign hit_power  = offset == cam_ctrl_pkg::OFF_CAM_POWER;
  assign hit_enable = offset == cam_ctrl_pkg::OFF_ISO_ENABLE;
  assign hit_single = offset == cam_ctrl_pkg::OFF_SINGLE_FRAME;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [2:0] rate_reg;
  logic [2:0] mode_reg;
  logic [2:0] format_reg;
  logic [3:0] chan_reg;
  logic [1:0] speed_reg;
  logic       power_reg;
  logic       enable_reg;
  logic       single_reg;
  logic       single_next;
  logic       single_req;

  cam_ctrl_pkg::single_frame_state_t sf_state_reg;
  cam_ctrl_pkg::single_frame_state_t sf_state_next;

  always_ff @(posedge clk) begin
    if (rst) begin
      rate_reg <= cam_ctrl_pkg::RST_SELECTOR;
    end else if (wr && hit_rate) begin
      rate_reg <= req_wdata[cam_ctrl_pkg::SEL_MSB:cam_ctrl_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= cam_ctrl_pkg::RST_SELECTOR;
    end else if (wr && hit_mode) begin
      mode_reg <= req_wdata[cam_ctrl_pkg::SEL_MSB:cam_ctrl_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      format_reg <= cam_ctrl_pkg::RST_SELECTOR;
    end else if (wr && hit_format) begin
      format_reg <= req_wdata[cam_ctrl_pkg::SEL_MSB:cam_ctrl_pkg::SEL_LSB];
    end
  end

  // channel and speed; reserved bits 4..5 are dropped on write
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_reg  <= cam_ctrl_pkg::RST_CHANNEL;
      speed_reg <= cam_ctrl_pkg::RST_SPEED;
    end else if (wr && hit_chan) begin
      chan_reg  <= req_wdata[cam_ctrl_pkg::CHAN_MSB:cam_ctrl_pkg::CHAN_LSB];
      speed_reg <= req_wdata[cam_ctrl_pkg::SPEED_MSB:cam_ctrl_pkg::SPEED_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_reg  <= cam_ctrl_pkg::RST_FLAG;
      enable_reg <= cam_ctrl_pkg::RST_FLAG;
    end else begin
      if (wr && hit_power) begin
        power_reg <= req_wdata[cam_ctrl_pkg::FLAG_BIT];
      end
      if (wr && hit_enable) begin
        enable_reg <= req_wdata[cam_ctrl_pkg::FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Single-frame sequencer
  // A request waits for the next frame start so a partial frame is never sent.

  assign single_req = wr && hit_single && req_wdata[cam_ctrl_pkg::FLAG_BIT] && !enable_reg;

  always_comb begin
    sf_state_next = sf_state_reg;
    single_next   = single_reg;
    unique case (sf_state_reg)
      cam_ctrl_pkg::SF_IDLE: begin
        if (single_req) begin
          sf_state_next = cam_ctrl_pkg::SF_WAIT;
          single_next   = 1'b1;
        end
      end
      cam_ctrl_pkg::SF_WAIT: begin
        if (frame_start) begin
          sf_state_next = cam_ctrl_pkg::SF_SEND;
        end
      end
      cam_ctrl_pkg::SF_SEND: begin
        if (frame_end) begin
          sf_state_next = cam_ctrl_pkg::SF_IDLE;
          single_next   = 1'b0;
        end
      end
      default: begin
        sf_state_next = cam_ctrl_pkg::SF_IDLE;
        single_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sf_state_reg <= cam_ctrl_pkg::SF_IDLE;
      single_reg   <= cam_ctrl_pkg::RST_FLAG;
    end else begin
      sf_state_reg <= sf_state_next;
      single_reg   <= single_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rdata_mux;

  // MSB-first packing, reserved bits and offsets zero
  assign rdata_mux =
    !in_bank   ? 32'h0000_0000 :
    hit_rate   ? {rate_reg, 29'h0000_0000} :
    hit_mode   ? {mode_reg, 29'h0000_0000} :
    hit_format ? {format_reg, 29'h0000_0000} :
    hit_chan   ? {chan_reg, 2'h0, speed_reg, 24'h00_0000} :
    hit_power  ? {power_reg, 31'h0000_0000} :
    hit_enable ? {enable_reg, 31'h0000_0000} :
    hit_single ? {single_reg, 31'h0000_0000} :
                 32'h0000_0000;

  // One-cycle response to every request; hit low means not this bank
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_hit   <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else begin
      resp_valid <= req_valid;
      resp_hit   <= req_valid && in_bank;
      resp_rdata <= rd ? rdata_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_rate      <= cam_ctrl_pkg::RST_SELECTOR;
      video_mode      <= cam_ctrl_pkg::RST_SELECTOR;
      video_format    <= cam_ctrl_pkg::RST_SELECTOR;
      iso_channel     <= cam_ctrl_pkg::RST_CHANNEL;
      iso_speed       <= cam_ctrl_pkg::RST_SPEED;
      cam_power       <= cam_ctrl_pkg::RST_FLAG;
      video_tx_enable <= cam_ctrl_pkg::RST_FLAG;
    end else begin
      frame_rate      <= rate_reg;
      video_mode      <= mode_reg;
      video_format    <= format_reg;
      iso_channel     <= chan_reg;
      iso_speed       <= speed_reg;
      cam_power       <= power_reg;
      video_tx_enable <= enable_reg || (sf_state_next == cam_ctrl_pkg::SF_SEND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_rate_write;
    @(posedge clk) disable iff (rst)
      (wr && hit_rate) |=> ##1 (frame_rate == $past(req_wdata[31:29], 2));
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("frame rate output not updated from write");

  property p_init_zero;
    @(posedge clk) disable iff (rst)
      (rd && in_bank && hit_init) |=> (resp_valid && resp_hit && resp_rdata == 32'h0000_0000);
  endproperty
  a_init_zero: assert property (p_init_zero)
    else $error("initialize register read not zero");

  property p_chan_read;
    @(posedge clk) disable iff (rst)
      (rd && in_bank && hit_chan) |=> (resp_rdata[27:26] == 2'h0 && resp_rdata[23:0] == 24'h0
        && resp_rdata[31:28] == $past(chan_reg) && resp_rdata[25:24] == $past(speed_reg));
  endproperty
  a_chan_read: assert property (p_chan_read)
    else $error("channel and speed read back wrong");

  property p_foreign_miss;
    @(posedge clk) disable iff (rst)
      (req_valid && !base_match) |=> (resp_valid && !resp_hit && resp_rdata == 32'h0000_0000);
  endproperty
  a_foreign_miss: assert property (p_foreign_miss)
    else $error("address outside base claimed");

  property p_power_pin;
    @(posedge clk) disable iff (rst)
      (wr && hit_power) |=> ##1 (cam_power == $past(req_wdata[31], 2));
  endproperty
  a_power_pin: assert property (p_power_pin)
    else $error("power pin does not follow power bit");

  property p_enable_tx;
    @(posedge clk) disable iff (rst)
      enable_reg |=> video_tx_enable;
  endproperty
  a_enable_tx: assert property (p_enable_tx)
    else $error("transmit not enabled under continuous enable");

  property p_single_ignored;
    @(posedge clk) disable iff (rst)
      (wr && hit_single && enable_reg && sf_state_reg == cam_ctrl_pkg::SF_IDLE)
        |=> (sf_state_reg == cam_ctrl_pkg::SF_IDLE && !single_reg);
  endproperty
  a_single_ignored: assert property (p_single_ignored)
    else $error("single-frame request taken under continuous enable");

  property p_single_clear;
    @(posedge clk) disable iff (rst)
      (sf_state_reg == cam_ctrl_pkg::SF_SEND && frame_end) |=> (!single_reg ##1 !video_tx_enable
        || enable_reg);
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single-frame bit not cleared after frame");

  property p_single_start;
    @(posedge clk) disable iff (rst)
      (sf_state_reg == cam_ctrl_pkg::SF_WAIT && frame_start) |=> video_tx_enable;
  endproperty
  a_single_start: assert property (p_single_start)
    else $error("single frame not transmitted at frame start");

endmodule // camera_function_control_regs

//--- verif/cam_host_model.sv
// Host model: issues quadlet reads and writes to the camera register bank.
// Assumes a response registered on the same edge that takes the request.
`timescale 1ns/100ps

module cam_host_model (
  input  wire logic        clk,
  output logic             req_valid,
  output logic             req_write,
  output logic [47:0]      req_addr,
  output logic [31:0]      req_wdata,
  input  wire logic        resp_valid,
  input  wire logic        resp_hit,
  input  wire logic [31:0] resp_rdata
);
  ////////////////////////////////////////////////////////////////
  // Idle lines at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 48'h0;
    req_wdata = 32'h0;
  end

  // One transfer; released lines flip so stale values are never trusted
  task automatic xfer(input logic wr, input logic [47:0] a, input logic [31:0] wd,
                      output logic v, output logic h, output logic [31:0] rd);
    logic [31:0] d;
    d = wd;
    if (wr && a[11:0] == cam_ctrl_pkg::OFF_ISO_CHAN_SPD && d[25:24] == 2'h3) d[25:24] = 2'h2;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    req_write <= ~wr;
    req_addr  <= ~a;
    req_wdata <= ~d;
    #1;
    v  = resp_valid;
    h  = resp_hit;
    rd = resp_rdata;
  endtask
endmodule // cam_host_model

//--- verif/test_camera_function_control_regs.sv
// Testbench for the camera function control register bank.
// Assumes a host model on the request port and drives frame pulses itself.
`timescale 1ns/100ps

module test_camera_function_control_regs;
  logic        clk, rst, req_valid, req_write, resp_valid, resp_hit;
  logic [47:0] req_addr;
  logic [31:0] req_wdata, resp_rdata, wd;
  logic        frame_start, frame_end, cam_power, video_tx_enable;
  logic [2:0]  frame_rate, video_mode, video_format;
  logic [3:0]  iso_channel;
  logic [1:0]  iso_speed;
  logic        v, h;
  logic [31:0] rd;
  int          checks, bad_count, i, j;
  integer      seed = 32'h220814ab;
  logic [11:0] offs [10] = '{cam_ctrl_pkg::OFF_INITIALIZE, cam_ctrl_pkg::OFF_FRAME_RATE,
    cam_ctrl_pkg::OFF_VIDEO_MODE, cam_ctrl_pkg::OFF_VIDEO_FORMAT, cam_ctrl_pkg::OFF_ISO_CHAN_SPD,
    cam_ctrl_pkg::OFF_CAM_POWER, cam_ctrl_pkg::OFF_ISO_ENABLE, cam_ctrl_pkg::OFF_RSVD_618,
    12'h620, cam_ctrl_pkg::OFF_RSVD_LAST};

  camera_function_control_regs uut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_hit(resp_hit), .resp_rdata(resp_rdata),
    .frame_start(frame_start), .frame_end(frame_end), .frame_rate(frame_rate),
    .video_mode(video_mode), .video_format(video_format), .iso_channel(iso_channel),
    .iso_speed(iso_speed), .cam_power(cam_power), .video_tx_enable(video_tx_enable));

  cam_host_model host (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_hit(resp_hit), .resp_rdata(resp_rdata));

  ////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs a few hundred cycles at most
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    bad_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////
  // Expected read-back: only the defined fields survive
  function automatic logic [31:0] sel_exp(input logic [31:0] w);
    return {w[31:29], 29'h0};
  endfunction
  function automatic logic [31:0] chan_exp(input logic [31:0] w);
    return {w[31:28], 2'h0, w[25:24], 24'h0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Access inside the bank; writes answer with zero data
  task automatic acc(input logic wr, input logic [11:0] off, input logic [31:0] d,
                     input logic [31:0] exp);
    host.xfer(wr, cam_ctrl_pkg::BASE_ADDR | {36'h0, off}, d, v, h, rd);
    check({31'h0, v & h}, 32'h1);
    check(rd, wr ? 32'h0 : exp);
  endtask

  // Lets registered outputs follow the registers
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic e);
    @(posedge clk);
    if (e) frame_end <= 1'b1;
    else frame_start <= 1'b1;
    @(posedge clk);
    frame_end   <= 1'b0;
    frame_start <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    frame_start = 1'b0;
    frame_end = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[k]) acc(1'b0, offs[k], 32'h0, 32'h0);
    // Every control pin must come out of reset low, power off and transmit stopped
    check({15'h0, frame_rate, video_mode, video_format, iso_channel, iso_speed, cam_power,
           video_tx_enable}, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      for (j = 1; j < 4; j++) begin
        wd = $random(seed);
        wd[31:29] = i[2:0];
        acc(1'b1, offs[j], wd, 32'h0);
        acc(1'b0, offs[j], 32'h0, sel_exp(wd));
      end
      settle();
      check({23'h0, frame_rate, video_mode, video_format}, {23'h0, {3{i[2:0]}}});
    end
    $display("test selectors done");
    for (i = 0; i < 16; i++) begin
      wd = $random(seed);
      wd[31:28] = i[3:0];
      wd[25:24] = 2'(i % 3);
      acc(1'b1, cam_ctrl_pkg::OFF_ISO_CHAN_SPD, wd, 32'h0);
      acc(1'b0, cam_ctrl_pkg::OFF_ISO_CHAN_SPD, 32'h0, chan_exp(wd));
      settle();
      check({26'h0, iso_channel, iso_speed}, {26'h0, wd[31:28], wd[25:24]});
    end
    $display("test channel done");
    for (i = 1; i >= 0; i--) begin
      wd = $random(seed);
      wd[31] = i[0];
      acc(1'b1, cam_ctrl_pkg::OFF_CAM_POWER, wd, 32'h0);
      acc(1'b0, cam_ctrl_pkg::OFF_CAM_POWER, 32'h0, {i[0], 31'h0});
      acc(1'b1, cam_ctrl_pkg::OFF_ISO_ENABLE, wd, 32'h0);
      acc(1'b0, cam_ctrl_pkg::OFF_ISO_ENABLE, 32'h0, {i[0], 31'h0});
      settle();
      check({30'h0, cam_power, video_tx_enable}, {30'h0, {2{i[0]}}});
    end
    $display("test flags done");
    // A write just off the base must miss and change nothing
    host.xfer(1'b1, 48'hFFFF_F0F1_0600, 32'h0, v, h, rd);
    check({30'h0, v, h}, 32'h2);
    foreach (offs[k]) if (k == 0 || k > 6) acc(1'b1, offs[k], 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, cam_ctrl_pkg::OFF_FRAME_RATE, 32'h0, 32'hE000_0000);
    acc(1'b0, cam_ctrl_pkg::OFF_RSVD_618, 32'h0, 32'h0);
    acc(1'b0, cam_ctrl_pkg::OFF_INITIALIZE, 32'h0, 32'h0);
    $display("test decode done");
    acc(1'b1, cam_ctrl_pkg::OFF_SINGLE_FRAME, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, cam_ctrl_pkg::OFF_SINGLE_FRAME, 32'h0, 32'h8000_0000);
    settle();
    check({31'h0, video_tx_enable}, 32'h0);
    pulse(1'b0);
    repeat ($unsigned($random(seed)) % 8 + 1) settle();
    check({31'h0, video_tx_enable}, 32'h1);
    pulse(1'b1);
    settle();
    check({31'h0, video_tx_enable}, 32'h0);
    acc(1'b0, cam_ctrl_pkg::OFF_SINGLE_FRAME, 32'h0, 32'h0);
    pulse(1'b0);
    settle();
    check({31'h0, video_tx_enable}, 32'h0);
    $display("test single frame done");
    acc(1'b1, cam_ctrl_pkg::OFF_ISO_ENABLE, 32'h8000_0000, 32'h0);
    acc(1'b1, cam_ctrl_pkg::OFF_SINGLE_FRAME, 32'h8000_0000, 32'h0);
    acc(1'b0, cam_ctrl_pkg::OFF_SINGLE_FRAME, 32'h0, 32'h0);
    acc(1'b1, cam_ctrl_pkg::OFF_ISO_ENABLE, 32'h0, 32'h0);
    pulse(1'b0);
    settle();
    check({31'h0, video_tx_enable}, 32'h0);
    $display("test ignore done");
    wrap_up();
  end
endmodule // test_camera_function_control_regs
